// [rtl/sram_host_pkg.sv]
// Constants for the asynchronous 8K x 9 SRAM host controller
package sram_host_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 9;
    localparam int CLK_PERIOD_NS = 10;
    // Access and cycle figures of the fastest grade
    localparam int READ_CYCLE_TIME_NS = 25;
    localparam int WRITE_CYCLE_TIME_NS = 25;
    localparam int ACCESS_TIME_NS = 25;
    localparam int WRITE_PULSE_NS = 18;
    localparam int POWER_DOWN_DELAY_NS = 20;
    // Least times round up to whole cycles
    localparam int READ_CYC = (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = (WRITE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PD_CYC = (POWER_DOWN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_WSETUP = 3'b010,
        ST_WPULSE = 3'b011,
        ST_WHOLD = 3'b100,
        ST_PDOWN = 3'b101
    } state_t;
endpackage

// [rtl/sram_cycle_if.sv]
// Interface carrying the cycle timer between controller and counter
`timescale 1ns/1ps
interface sram_cycle_if;
    logic load;
    logic [sram_host_pkg::CNT_W-1:0] value;
    logic done;
    modport ctrl (output load, output value, input done);
    modport timer (input load, input value, output done);
endinterface

// [rtl/sram_cycle_timer.sv]
// Down counter timing the phases of an SRAM access
`timescale 1ns/1ps
module sram_cycle_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Timer port
    sram_cycle_if.timer tmr
);
    logic [sram_host_pkg::CNT_W-1:0] count_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            count_q <= '0;
        end else if (tmr.load) begin
            count_q <= tmr.value;
        end else if (count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end

    // Done depends on the count alone; the load decode reads it, so no loop back
    assign tmr.done = (count_q == '0);

    a_timer_counts: assert property (@(posedge clk) disable iff (reset)
        tmr.load && tmr.value != '0 |=> !tmr.done)
        else $error("timer done right after nonzero load");
endmodule

// [rtl/sram_host_ctrl.sv]
// Host controller driving an asynchronous 8K x 9 SRAM through its pins
//
// Functional notes
// - Write strobe stays high during reads
// - Write asserts both selects and write strobe
// - Address valid before selects assert
// - Read cycle runs address to address
// - Write cycle runs address to address
`timescale 1ns/1ps
module sram_host_ctrl #(
    parameter int ADDR_W = sram_host_pkg::ADDR_W,
    parameter int DATA_W = sram_host_pkg::DATA_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // User request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    // User answer
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // SRAM pins
    output logic [ADDR_W-1:0] addr,
    output logic chip_select_n,
    output logic chip_select_active_high,
    output logic output_enable_n,
    output logic write_strobe_n,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe
);
    if (ADDR_W != sram_host_pkg::ADDR_W || DATA_W != sram_host_pkg::DATA_W) begin : g_bad_size
        $error("SRAM host supports only the 8K x 9 organisation");
    end

    sram_cycle_if cyc ();
    sram_cycle_timer u_timer (
        .clk(clk),
        .reset(reset),
        .tmr(cyc.timer)
    );

    sram_host_pkg::state_t state_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic rsp_q;
    logic sel_q;
    logic oe_n_q;
    logic we_n_q;
    logic doe_q;
    logic take;

    function automatic logic [sram_host_pkg::CNT_W-1:0] cyc_count(input int n);
        cyc_count = sram_host_pkg::CNT_W'(n - 1);
    endfunction

    assign req_ready = (state_q == sram_host_pkg::ST_IDLE) && cyc.done;
    assign take = req_valid && req_ready;

    // Phase sequencer and timer loads
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= sram_host_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                sram_host_pkg::ST_IDLE: begin
                    if (take && req_write) begin
                        state_q <= sram_host_pkg::ST_WSETUP;
                    end else if (take) begin
                        state_q <= sram_host_pkg::ST_READ;
                    end
                end
                sram_host_pkg::ST_READ: begin
                    if (cyc.done) begin
                        state_q <= sram_host_pkg::ST_PDOWN;
                    end
                end
                sram_host_pkg::ST_WSETUP: begin
                    state_q <= sram_host_pkg::ST_WPULSE;
                end
                sram_host_pkg::ST_WPULSE: begin
                    if (cyc.done) begin
                        state_q <= sram_host_pkg::ST_WHOLD;
                    end
                end
                sram_host_pkg::ST_WHOLD: begin
                    state_q <= sram_host_pkg::ST_PDOWN;
                end
                sram_host_pkg::ST_PDOWN: begin
                    if (cyc.done) begin
                        state_q <= sram_host_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= sram_host_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        cyc.load = 1'b0;
        cyc.value = '0;
        if (take && !req_write) begin
            // Selects rise one edge after this load, so the window needs one count more
            cyc.load = 1'b1;
            cyc.value = cyc_count(sram_host_pkg::READ_CYC + 1);
        end else if (state_q == sram_host_pkg::ST_WSETUP) begin
            cyc.load = 1'b1;
            cyc.value = cyc_count(sram_host_pkg::PULSE_CYC);
        end else if ((state_q == sram_host_pkg::ST_READ && cyc.done)
                     || state_q == sram_host_pkg::ST_WHOLD) begin
            cyc.load = 1'b1;
            cyc.value = cyc_count(sram_host_pkg::PD_CYC);
        end
    end

    // Address and write data are latched at acceptance and held to the next one
    always_ff @(posedge clk) begin
        if (reset) begin
            addr_q <= '0;
            wdata_q <= '0;
        end else if (take) begin
            addr_q <= req_addr;
            wdata_q <= req_wdata;
        end
    end

    // Selects assert one cycle after the address settles
    always_ff @(posedge clk) begin
        if (reset) begin
            sel_q <= 1'b0;
        end else begin
            sel_q <= (state_q == sram_host_pkg::ST_READ) && !cyc.done
                     || state_q == sram_host_pkg::ST_WSETUP
                     || state_q == sram_host_pkg::ST_WPULSE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= !((state_q == sram_host_pkg::ST_READ) && !cyc.done);
        end
    end

    // Write strobe low only inside the pulse, never while reading
    always_ff @(posedge clk) begin
        if (reset) begin
            we_n_q <= 1'b1;
        end else begin
            we_n_q <= !(state_q == sram_host_pkg::ST_WSETUP
                        || (state_q == sram_host_pkg::ST_WPULSE && !cyc.done));
        end
    end

    // Host drives data only during a write, released after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            doe_q <= 1'b0;
        end else begin
            doe_q <= state_q == sram_host_pkg::ST_WSETUP
                     || state_q == sram_host_pkg::ST_WPULSE;
        end
    end

    // Read data captured at the end of the access window
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= '0;
            rsp_q <= 1'b0;
        end else begin
            rsp_q <= (state_q == sram_host_pkg::ST_READ) && cyc.done;
            if ((state_q == sram_host_pkg::ST_READ) && cyc.done) begin
                rdata_q <= data_in;
            end
        end
    end

    assign addr = addr_q;
    assign chip_select_n = !sel_q;
    assign chip_select_active_high = sel_q;
    assign output_enable_n = oe_n_q;
    assign write_strobe_n = we_n_q;
    assign data_out = wdata_q;
    assign data_oe = doe_q;
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rdata_q;

    a_read_no_write: assert property (@(posedge clk) disable iff (reset)
        !output_enable_n |-> write_strobe_n)
        else $error("write strobe low during read");
    a_write_selects: assert property (@(posedge clk) disable iff (reset)
        !write_strobe_n |-> !chip_select_n && chip_select_active_high)
        else $error("write strobe without both selects");
    a_selects_match: assert property (@(posedge clk) disable iff (reset)
        chip_select_n != chip_select_active_high)
        else $error("selects differ in timing");
    a_addr_stable_sel: assert property (@(posedge clk) disable iff (reset)
        $rose(chip_select_active_high) |-> $stable(addr))
        else $error("address changed as selects asserted");
    a_addr_no_strobe: assert property (@(posedge clk) disable iff (reset)
        !write_strobe_n |-> $stable(addr))
        else $error("address moved under write strobe");
    a_data_bus_write: assert property (@(posedge clk) disable iff (reset)
        data_oe |-> output_enable_n)
        else $error("bus contention with read");
    a_read_cycle_len: assert property (@(posedge clk) disable iff (reset)
        $rose(!output_enable_n) |-> !output_enable_n [*3])
        else $error("read window shorter than cycle time");
    a_write_pulse_len: assert property (@(posedge clk) disable iff (reset)
        $fell(write_strobe_n) |-> !write_strobe_n [*2])
        else $error("write pulse too short");
    a_power_down: assert property (@(posedge clk) disable iff (reset)
        $rose(chip_select_n) |-> !req_ready [*2])
        else $error("new access before power-down delay");
    a_deselect_float: assert property (@(posedge clk) disable iff (reset)
        chip_select_n |-> output_enable_n && write_strobe_n)
        else $error("strobes active while deselected");
    a_read_answer: assert property (@(posedge clk) disable iff (reset)
        take && !req_write |-> ##5 rsp_valid)
        else $error("read answer late");

    c_read: cover property (@(posedge clk) take && !req_write);
    c_write: cover property (@(posedge clk) take && req_write);
    c_back_to_back: cover property (@(posedge clk) take ##[1:10] take);
endmodule

// [testbench/sram_device_model.sv]
// Behavioural 8K x 9 asynchronous SRAM facing the host controller
`timescale 1ns/1ps
module sram_device_model (
    // Control pins
    input wire logic [12:0] addr,
    input wire logic chip_select_n,
    input wire logic chip_select_active_high,
    input wire logic output_enable_n,
    input wire logic write_strobe_n,
    // Data pins
    input wire logic host_oe,
    input wire logic [8:0] bus,
    output logic [8:0] dq,
    output logic dq_oe,
    // Status
    output int n_viol
);
    logic [8:0] mem [0:8191];
    logic sel;
    logic ok;
    realtime t_chg;
    realtime t_desel;
    assign sel = !chip_select_n && chip_select_active_high;
    assign dq_oe = sel && !output_enable_n && write_strobe_n;
    // Wrong data until the access time has run out
    assign dq = ok ? mem[addr] : ~mem[addr];
    initial begin
        n_viol = 0;
        t_chg = 0.0;
        t_desel = 0.0;
        ok = 1'b0;
    end
    // Standby is only reached once the power-down delay has run after deselect
    always @(negedge sel) t_desel = $realtime;
    always @(posedge sel) if ($realtime - t_desel < sram_host_pkg::POWER_DOWN_DELAY_NS) n_viol++;
    always @(addr, dq_oe) t_chg = $realtime;
    always #1 ok = dq_oe && ($realtime - t_chg >= sram_host_pkg::ACCESS_TIME_NS);
    always @(posedge write_strobe_n) if (sel) mem[addr] = bus;
    // Address may only move while deselected; a change with deselect is legal
    always @(addr) #0.1 if (sel) n_viol++;
    always @(host_oe, dq_oe) if (host_oe && dq_oe) n_viol++;
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the SRAM host controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
    logic clk, reset, req_valid, req_ready, req_write, rsp_valid, data_oe, dq_oe;
    logic chip_select_n, chip_select_active_high, output_enable_n, write_strobe_n;
    logic [12:0] req_addr, addr;
    logic [8:0] req_wdata, rsp_rdata, data_in, data_out, dq, bus_last, exp_v;
    logic [5:0] pins;
    int n_mismatch, total_checks, n_viol, n;
    logic [8:0] shadow [logic [12:0]];
    logic [8:0] exp_q [$];
    logic [12:0] wr_q [$];
    logic [12:0] edge_a [4] = '{13'h0000, 13'h1FFF, 13'h0AAA, 13'h1555};
    logic [8:0] edge_d [4] = '{9'h000, 9'h1FF, 9'h155, 9'h0AA};
    assign data_in = data_oe ? data_out : (dq_oe ? dq : ~bus_last);
    assign pins = {chip_select_n, chip_select_active_high, output_enable_n, write_strobe_n,
        data_oe, req_ready};
    sram_host_ctrl dut (.clk(clk), .reset(reset), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .addr(addr),
        .chip_select_n(chip_select_n), .chip_select_active_high(chip_select_active_high),
        .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
    sram_device_model ram (.addr(addr), .chip_select_n(chip_select_n),
        .chip_select_active_high(chip_select_active_high),
        .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
        .host_oe(data_oe), .bus(data_in), .dq(dq), .dq_oe(dq_oe), .n_viol(n_viol));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (data_oe || dq_oe) bus_last <= data_in;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Holds the request until taken; valid stays up so a busy controller is tested
    task automatic req(input logic w, input logic [12:0] ad, input logic [8:0] d);
        int k;
        k = 0;
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= ad;
        req_wdata <= d;
        @(negedge clk);
        while (req_ready !== 1'b1) begin
            k++;
            if (k > 20) begin
                n_mismatch++;
                print_verdict();
            end
            @(negedge clk);
        end
        if (w) shadow[ad] = d;
        if (w) wr_q.push_back(ad);
        else exp_q.push_back(shadow[ad]);
        @(posedge clk);
    endtask
    task automatic drain();
        n = 0;
        while (exp_q.size() != 0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) n_mismatch++;
    endtask
    always @(negedge clk) begin
        if (!reset) begin
            `CHK("cs_pair", ~chip_select_n, chip_select_active_high)
            if (!write_strobe_n) `CHK("wr_sel", 2'b01, {chip_select_n, chip_select_active_high})
            if (!output_enable_n) `CHK("rd_strobe", 1'b1, write_strobe_n)
            if (rsp_valid === 1'b1) begin
                exp_v = exp_q.pop_front();
                `CHK("rdata", exp_v, rsp_rdata)
            end
        end
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h047536E7));
        reset = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 13'h0000;
        req_wdata = 9'h000;
        bus_last = 9'h000;
        n_mismatch = 0;
        total_checks = 0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        `CHK("idle", 6'h2D, pins)
        @(posedge clk);
        for (int i = 0; i < 4; i++) req(1'b1, edge_a[i], edge_d[i]);
        for (int i = 0; i < 4; i++) req(1'b0, edge_a[i], 9'h000);
        for (int i = 0; i < 40; i++) begin
            if ($urandom_range(1)) req(1'b1, 13'($urandom), 9'($urandom));
            else req(1'b0, wr_q[$urandom_range(wr_q.size() - 1)], 9'h000);
        end
        req(1'b0, wr_q[0], 9'h000);
        repeat (5) @(posedge clk);
        reset <= 1'b1;
        req_valid <= 1'b0;
        @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        `CHK("idle2", 6'h2D, pins)
        @(posedge clk);
        req(1'b0, edge_a[1], 9'h000);
        req_valid <= 1'b0;
        drain();
        `CHK("pin_order", 0, n_viol)
        print_verdict();
    end
endmodule
